// [core/chunk_store.sv]
`timescale 1ns/100ps
module chunk_store #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic sys_clk_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [WIDTH-1:0] rd_data_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule

// [core/sensor_bootloader_regs.sv]
`timescale 1ns/100ps
// Function
// - Application revision reads as two bytes: major, then minor.
// - Fault-source register explains the status fault flag in bit 0.
// - Write selecting a nonexistent register sets fault bit 0.
// - Read of an invalid register sets fault bit 1.
// - Unsupported sampling setting write sets fault bit 2.
// - Sensor faults set bits 3, 4 and 5.
// - Fault bits 6 and 7 are reserved, always zero.
// - Restart into boot mode only after exact four-byte key in one transaction.
// - Respond to address 0x5A or 0x5B chosen by select pin.
// - Boot mode exposes status and two-byte boot revision.
// - Hardware identity and revision bytes are read only.
// - Erase starts only after exact four-byte erase key.
// - Status bit 6 sets on erase done, clears on reset or start.
// - Nine-byte chunks are written in sequence into the chunk store.
// - Verify write checks the whole image and keeps the result.
// - Status bit 5 sets on verify done, clears on reset or start.
// - Bare address write of 0xF4 starts application if image valid.
module sensor_bootloader_regs #(
    parameter int DEPTH = boot_regs_pkg::CHUNK_DEPTH,
    parameter logic [15:0] APP_REV = 16'h2000
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_oe_n_o,
    input wire logic addr_sel_i,
    input wire logic max_resist_i,
    input wire logic hotplate_current_fault_i,
    input wire logic hotplate_voltage_fault_i,
    input wire logic wipe_done_i,
    input wire logic check_done_i,
    input wire logic check_pass_i,
    output logic wipe_start_o,
    output logic check_start_o,
    output logic restart_o,
    output logic app_run_o,
    output logic [5:0] chunk_count_o
);
    localparam int AW = $clog2(DEPTH);

    // ------------------------------------------------
    // Link side: I2C slave on the SCL clock.
    // ------------------------------------------------
    typedef enum {L_IDLE, L_ADDR, L_ADDR_ACK, L_WBYTE, L_WACK, L_RBYTE, L_RACK} link_state_t;
    link_state_t l_state_reg;
    logic [7:0] l_shift_reg;
    logic [2:0] l_bit_reg;
    logic l_first_reg;
    logic [3:0] l_wcount_reg;
    logic [7:0] l_ptr_reg;
    logic [71:0] l_data_reg;
    logic [7:0] l_rdbyte;
    logic l_start_tgl_reg;

    // A falling SDA while SCL is high marks a start; the link logic takes it at the next SCL rise.
    logic s_start_tgl_reg;
    always_ff @(negedge sda_i or posedge rst_i) begin
        if (rst_i) begin
            s_start_tgl_reg <= 1'b0;
        end else if (scl_i) begin
            s_start_tgl_reg <= ~s_start_tgl_reg;
        end
    end
    always_ff @(posedge scl_i or posedge rst_i) begin
        if (rst_i) begin
            l_start_tgl_reg <= 1'b0;
        end else begin
            l_start_tgl_reg <= s_start_tgl_reg;
        end
    end
    logic l_new_frame;
    assign l_new_frame = l_start_tgl_reg != s_start_tgl_reg;

    // Completed transactions go to the system domain as word plus toggle.
    logic l_done_tgl_reg, l_rd_tgl_reg;
    logic [3:0] l_done_count_reg;
    logic [7:0] l_done_reg_reg;
    logic [71:0] l_done_data_reg;
    logic l_addr_ok;
    assign l_addr_ok = l_shift_reg[7:1] == (addr_sel_i ? boot_regs_pkg::DEV_ADDR_HI
                                                       : boot_regs_pkg::DEV_ADDR_LO);

    always_ff @(posedge scl_i or posedge rst_i) begin
        if (rst_i) begin
            l_state_reg <= L_IDLE;
            l_shift_reg <= 8'h00;
            l_bit_reg <= 3'h0;
            l_first_reg <= 1'b1;
            l_wcount_reg <= 4'h0;
            l_ptr_reg <= 8'h00;
            l_data_reg <= '0;
            l_done_tgl_reg <= 1'b0;
            l_rd_tgl_reg <= 1'b0;
            l_done_count_reg <= 4'h0;
            l_done_reg_reg <= 8'h00;
            l_done_data_reg <= '0;
        end else if (l_new_frame) begin
            // A repeated or fresh start closes any pending write.
            if (l_wcount_reg != 4'h0) begin
                l_done_tgl_reg <= ~l_done_tgl_reg;
                l_done_count_reg <= l_wcount_reg;
                l_done_reg_reg <= l_ptr_reg;
                l_done_data_reg <= l_data_reg;
            end
            l_wcount_reg <= 4'h0;
            l_shift_reg <= {7'h00, sda_i};
            l_bit_reg <= 3'h1;
            l_state_reg <= L_ADDR;
        end else begin
            case (l_state_reg)
                L_ADDR: begin
                    l_shift_reg <= {l_shift_reg[6:0], sda_i};
                    l_bit_reg <= l_bit_reg + 3'h1;
                    if (l_bit_reg == 3'h7) l_state_reg <= L_ADDR_ACK;
                end
                L_ADDR_ACK: begin
                    l_bit_reg <= 3'h0;
                    l_first_reg <= 1'b1;
                    if (!l_addr_ok) begin
                        l_state_reg <= L_IDLE;
                    end else if (l_shift_reg[0]) begin
                        l_state_reg <= L_RBYTE;
                        l_rd_tgl_reg <= ~l_rd_tgl_reg;
                    end else begin
                        l_state_reg <= L_WBYTE;
                    end
                end
                L_WBYTE: begin
                    l_shift_reg <= {l_shift_reg[6:0], sda_i};
                    l_bit_reg <= l_bit_reg + 3'h1;
                    if (l_bit_reg == 3'h7) l_state_reg <= L_WACK;
                end
                L_WACK: begin
                    l_bit_reg <= 3'h0;
                    l_state_reg <= L_WBYTE;
                    if (l_first_reg) begin
                        l_ptr_reg <= l_shift_reg;
                        l_first_reg <= 1'b0;
                    end else if (l_wcount_reg != 4'(boot_regs_pkg::CHUNK_BYTES + 1)) begin
                        l_data_reg <= {l_data_reg[63:0], l_shift_reg};
                    end
                    if (l_wcount_reg != 4'hF) l_wcount_reg <= l_wcount_reg + 4'h1;
                end
                L_RBYTE: begin
                    l_bit_reg <= l_bit_reg + 3'h1;
                    if (l_bit_reg == 3'h7) l_state_reg <= L_RACK;
                end
                L_RACK: begin
                    l_bit_reg <= 3'h0;
                    l_first_reg <= 1'b0;
                    l_state_reg <= sda_i ? L_IDLE : L_RBYTE;
                end
                default: l_state_reg <= L_IDLE;
            endcase
        end
    end

    // SDA changes only while SCL is low, so the pin driver is updated on the falling SCL edge.
    always_ff @(negedge scl_i or posedge rst_i) begin
        if (rst_i) begin
            sda_oe_n_o <= 1'b1;
        end else begin
            case (l_state_reg)
                L_ADDR_ACK: sda_oe_n_o <= !l_addr_ok;
                L_WACK: sda_oe_n_o <= 1'b0;
                L_RBYTE: sda_oe_n_o <= l_rdbyte[3'h7 - l_bit_reg];
                default: sda_oe_n_o <= 1'b1;
            endcase
        end
    end

    // ------------------------------------------------
    // System side: registers and commands.
    // ------------------------------------------------
    logic [2:0] s_done_sync_reg, s_rd_sync_reg;
    logic [7:0] status_reg, fault_reg;
    logic [7:0] rd_ptr_reg;
    logic [7:0] rd_byte_reg;
    logic app_valid_reg;
    logic [AW-1:0] chunk_addr_reg;
    logic write_event, read_event;
    logic [7:0] fault_next;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_done_sync_reg <= 3'b000;
            s_rd_sync_reg <= 3'b000;
        end else begin
            s_done_sync_reg <= {s_done_sync_reg[1:0], l_done_tgl_reg};
            s_rd_sync_reg <= {s_rd_sync_reg[1:0], l_rd_tgl_reg};
        end
    end
    assign write_event = s_done_sync_reg[2] != s_done_sync_reg[1];
    assign read_event = s_rd_sync_reg[2] != s_rd_sync_reg[1];

    function automatic logic known_offset(input logic [7:0] ofs);
        case (ofs)
            boot_regs_pkg::OFS_STATUS, boot_regs_pkg::OFS_HW_IDENTITY, boot_regs_pkg::OFS_HW_REVISION,
            boot_regs_pkg::OFS_BOOT_REV, boot_regs_pkg::OFS_APP_REV, boot_regs_pkg::OFS_FAULT_SOURCE:
                known_offset = 1'b1;
            default: known_offset = 1'b0;
        endcase
    endfunction

    function automatic logic known_cmd(input logic [7:0] ofs);
        known_cmd = ofs inside {boot_regs_pkg::OFS_WIPE_KEY, boot_regs_pkg::OFS_CHUNK_PORT,
                                boot_regs_pkg::OFS_CHECK_TRIG, boot_regs_pkg::OFS_LAUNCH,
                                boot_regs_pkg::OFS_RESTART_KEY};
    endfunction

    logic key_ok, wipe_ok, chunk_ok, launch_ok;
    assign key_ok = write_event && l_done_reg_reg == boot_regs_pkg::OFS_RESTART_KEY
        && l_done_count_reg == 4'(boot_regs_pkg::KEY_BYTES + 1)
        && l_done_data_reg[31:0] == boot_regs_pkg::RESTART_KEY;
    assign wipe_ok = write_event && l_done_reg_reg == boot_regs_pkg::OFS_WIPE_KEY
        && l_done_count_reg == 4'(boot_regs_pkg::KEY_BYTES + 1)
        && l_done_data_reg[31:0] == boot_regs_pkg::WIPE_KEY;
    assign chunk_ok = write_event && l_done_reg_reg == boot_regs_pkg::OFS_CHUNK_PORT
        && l_done_count_reg == 4'(boot_regs_pkg::CHUNK_BYTES + 1);
    assign launch_ok = write_event && l_done_reg_reg == boot_regs_pkg::OFS_LAUNCH
        && l_done_count_reg == 4'h1 && app_valid_reg;

    always_comb begin
        fault_next = fault_reg;
        if (write_event && !known_cmd(l_done_reg_reg)
            && l_done_reg_reg != boot_regs_pkg::OFS_SAMPLING_SETTING
            && !(known_offset(l_done_reg_reg) && l_done_count_reg == 4'h1)) begin
            fault_next[boot_regs_pkg::FS_BAD_WRITE_ADDR] = 1'b1;
        end
        if (write_event && l_done_reg_reg == boot_regs_pkg::OFS_SAMPLING_SETTING) begin
            fault_next[boot_regs_pkg::FS_BAD_SAMPLING] = 1'b1;
        end
        if (read_event && !known_offset(l_ptr_reg)) begin
            fault_next[boot_regs_pkg::FS_BAD_READ_ADDR] = 1'b1;
        end
        if (max_resist_i) fault_next[boot_regs_pkg::FS_MAX_RESIST] = 1'b1;
        if (hotplate_current_fault_i) fault_next[boot_regs_pkg::FS_HOTPLATE_CURRENT] = 1'b1;
        if (hotplate_voltage_fault_i) fault_next[boot_regs_pkg::FS_HOTPLATE_VOLTAGE] = 1'b1;
        fault_next = fault_next & boot_regs_pkg::FS_USED_MASK;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_reg <= 8'h00;
        end else begin
            fault_reg <= fault_next;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_reg <= 8'h80;
            app_valid_reg <= 1'b0;
        end else begin
            status_reg[boot_regs_pkg::ST_FAULT] <= |fault_next;
            if (wipe_ok) app_valid_reg <= 1'b0;
            if (check_done_i) app_valid_reg <= check_pass_i;
            status_reg[boot_regs_pkg::ST_APP_VALID] <= app_valid_reg;
            if (launch_ok) begin
                status_reg[boot_regs_pkg::ST_WIPED] <= 1'b0;
                status_reg[boot_regs_pkg::ST_VERIFIED] <= 1'b0;
                status_reg[boot_regs_pkg::ST_BOOT_MODE] <= 1'b0;
            end
            if (wipe_done_i) status_reg[boot_regs_pkg::ST_WIPED] <= 1'b1;
            if (check_done_i) status_reg[boot_regs_pkg::ST_VERIFIED] <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wipe_start_o <= 1'b0;
            check_start_o <= 1'b0;
            restart_o <= 1'b0;
            app_run_o <= 1'b0;
            chunk_addr_reg <= '0;
            chunk_count_o <= 6'h00;
        end else begin
            wipe_start_o <= wipe_ok;
            restart_o <= key_ok;
            check_start_o <= write_event && l_done_reg_reg == boot_regs_pkg::OFS_CHECK_TRIG;
            if (launch_ok) app_run_o <= 1'b1;
            if (wipe_ok) chunk_addr_reg <= '0;
            if (chunk_ok) chunk_addr_reg <= chunk_addr_reg + 1'b1;
            chunk_count_o <= 6'(chunk_addr_reg);
        end
    end

    chunk_store #(.WIDTH(72), .DEPTH(DEPTH), .AW(AW)) u_store (
        .sys_clk_i(sys_clk_i),
        .wr_en_i(chunk_ok),
        .wr_addr_i(chunk_addr_reg),
        .wr_data_i(l_done_data_reg),
        .rd_addr_i(chunk_addr_reg),
        .rd_data_o()
    );

    // Read data is prepared on the system clock for the selected register.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_ptr_reg <= 8'h00;
            rd_byte_reg <= 8'h00;
        end else begin
            rd_ptr_reg <= l_ptr_reg;
            case (rd_ptr_reg)
                boot_regs_pkg::OFS_STATUS: rd_byte_reg <= status_reg;
                boot_regs_pkg::OFS_HW_IDENTITY: rd_byte_reg <= boot_regs_pkg::HW_IDENTITY_VAL;
                boot_regs_pkg::OFS_HW_REVISION: rd_byte_reg <= boot_regs_pkg::HW_REVISION_VAL;
                boot_regs_pkg::OFS_BOOT_REV: rd_byte_reg <= boot_regs_pkg::BOOT_REV_VAL[15:8];
                boot_regs_pkg::OFS_APP_REV: rd_byte_reg <= APP_REV[15:8];
                boot_regs_pkg::OFS_FAULT_SOURCE: rd_byte_reg <= fault_reg;
                default: rd_byte_reg <= 8'h00;
            endcase
        end
    end
    assign l_rdbyte = l_first_reg ? rd_byte_reg
        : (rd_ptr_reg == boot_regs_pkg::OFS_APP_REV ? APP_REV[7:0]
        : (rd_ptr_reg == boot_regs_pkg::OFS_BOOT_REV ? boot_regs_pkg::BOOT_REV_VAL[7:0] : 8'h00));

    // ------------------------------------------------
    // Checks.
    // ------------------------------------------------
    wipe_sticky_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        status_reg[6] && !launch_ok |=> status_reg[6]) else $error("Wipe flag dropped.");
    check_sticky_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        status_reg[5] && !launch_ok |=> status_reg[5]) else $error("Verify flag dropped.");
    wipe_key_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wipe_start_o |-> $past(wipe_ok)) else $error("Erase without key.");
    restart_key_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        restart_o |-> $past(l_done_data_reg[31:0]) == boot_regs_pkg::RESTART_KEY) else $error("Restart without key.");
    fault_reserved_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        fault_reg[7:6] == 2'b00) else $error("Reserved fault bits set.");
    fault_flag_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        |fault_reg |-> status_reg[0]) else $error("Fault flag missing.");
    launch_valid_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(app_run_o) |-> $past(app_valid_reg)) else $error("Start without valid image.");
    resist_fault_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        max_resist_i |=> fault_reg[3]) else $error("Resistance fault lost.");
endmodule

// [include/boot_regs_pkg.sv]
package boot_regs_pkg;
    // ----------------------------------------
    // Bus addresses and register offsets.
    // ----------------------------------------
    localparam logic [6:0] DEV_ADDR_LO = 7'h5A;
    localparam logic [6:0] DEV_ADDR_HI = 7'h5B;
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_HW_IDENTITY = 8'h20;
    localparam logic [7:0] OFS_HW_REVISION = 8'h21;
    localparam logic [7:0] OFS_BOOT_REV = 8'h23;
    localparam logic [7:0] OFS_APP_REV = 8'h24;
    localparam logic [7:0] OFS_FAULT_SOURCE = 8'hE0;
    localparam logic [7:0] OFS_WIPE_KEY = 8'hF1;
    localparam logic [7:0] OFS_CHUNK_PORT = 8'hF2;
    localparam logic [7:0] OFS_CHECK_TRIG = 8'hF3;
    localparam logic [7:0] OFS_LAUNCH = 8'hF4;
    localparam logic [7:0] OFS_RESTART_KEY = 8'hFF;
    localparam logic [7:0] OFS_SAMPLING_SETTING = 8'h01;
    // ----------------------------------------
    // Key sequences.
    // ----------------------------------------
    localparam logic [31:0] RESTART_KEY = 32'h11E5728A;
    localparam logic [31:0] WIPE_KEY = 32'hE7A7E609;
    localparam int KEY_BYTES = 4;
    localparam int CHUNK_BYTES = 9;
    // ----------------------------------------
    // Field positions.
    // ----------------------------------------
    localparam int ST_FAULT = 0;
    localparam int ST_VERIFIED = 5;
    localparam int ST_WIPED = 6;
    localparam int ST_APP_VALID = 4;
    localparam int ST_BOOT_MODE = 7;
    localparam int FS_BAD_WRITE_ADDR = 0;
    localparam int FS_BAD_READ_ADDR = 1;
    localparam int FS_BAD_SAMPLING = 2;
    localparam int FS_MAX_RESIST = 3;
    localparam int FS_HOTPLATE_CURRENT = 4;
    localparam int FS_HOTPLATE_VOLTAGE = 5;
    localparam logic [7:0] FS_USED_MASK = 8'h3F;
    // ----------------------------------------
    // Arbitrary identity values.
    // ----------------------------------------
    localparam logic [7:0] HW_IDENTITY_VAL = 8'hA5;
    localparam logic [7:0] HW_REVISION_VAL = 8'h20;
    localparam logic [15:0] BOOT_REV_VAL = 16'h1000;
    localparam int CHUNK_DEPTH = 64;
endpackage

// [verif/i2c_host_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Host side of the two-wire link.
// ----------------------------------------
module i2c_host_model (
    output logic scl_o,
    output logic sda_o,
    input wire logic sda_i
);
    // The clock stands high and data is released between frames.
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic bit_io(input logic b, output logic r);
        sda_o = b;
        #8 scl_o = 1'b1;
        #15 r = sda_i;
        #1 scl_o = 1'b0;
        #8;
    endtask
    task automatic start();
        sda_o = 1'b1;
        #8 scl_o = 1'b1;
        #16 sda_o = 1'b0;
        #16 scl_o = 1'b0;
        #8;
    endtask
    task automatic stop();
        sda_o = 1'b0;
        #8 scl_o = 1'b1;
        #16 sda_o = 1'b1;
        #16;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // The last byte of a read is not acknowledged, so no byte beyond the register is fetched.
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, r);
    endtask
endmodule

// [verif/testbench.sv]
`timescale 1ns/100ps
module testbench;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic addr_sel_i = 1'b0;
    logic max_resist_i = 1'b0;
    logic hotplate_current_fault_i = 1'b0;
    logic hotplate_voltage_fault_i = 1'b0;
    logic wipe_done_i = 1'b0;
    logic check_done_i = 1'b0;
    logic check_pass_i = 1'b0;
    logic scl_i, host_sda, sda_oe_n_o, wipe_start_o, check_start_o, restart_o, app_run_o, ack;
    logic [5:0] chunk_count_o;
    logic [15:0] v;
    logic [6:0] dev = 7'h5A;
    wire sda_i = host_sda & sda_oe_n_o;
    int failures = 0, check_count = 0, wipes = 0, verifies = 0, restarts = 0, exp_st = 'h80;
    localparam logic [7:0] RD_OFS [5] = '{8'h00, 8'h20, 8'h21, 8'h23, 8'h24};
    localparam logic [15:0] RD_EXP [5] = '{16'h0080, 16'(boot_regs_pkg::HW_IDENTITY_VAL),
        16'(boot_regs_pkg::HW_REVISION_VAL), boot_regs_pkg::BOOT_REV_VAL, 16'h2000};
    always #25 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        wipes += int'(wipe_start_o);
        verifies += int'(check_start_o);
        restarts += int'(restart_o);
    end
    i2c_host_model i_host (.scl_o(scl_i), .sda_o(host_sda), .sda_i(sda_i));
    sensor_bootloader_regs i_dut (.sys_clk_i, .rst_i, .scl_i, .sda_i, .sda_oe_n_o, .addr_sel_i,
        .max_resist_i, .hotplate_current_fault_i, .hotplate_voltage_fault_i, .wipe_done_i,
        .check_done_i, .check_pass_i, .wipe_start_o, .check_start_o, .restart_o, .app_run_o,
        .chunk_count_o);
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] ofs, input int n, input logic [71:0] d);
        i_host.start();
        i_host.wbyte({dev, 1'b0}, ack);
        i_host.wbyte(ofs, ack);
        for (int i = n - 1; i >= 0; i--) begin
            i_host.wbyte(d[8 * i +: 8], ack);
        end
        i_host.stop();
    endtask
    task automatic rd(input logic [7:0] ofs, input int n, output logic [15:0] val);
        logic [7:0] b;
        val = 16'h0000;
        i_host.start();
        i_host.wbyte({dev, 1'b0}, ack);
        i_host.wbyte(ofs, ack);
        i_host.start();
        i_host.wbyte({dev, 1'b1}, ack);
        for (int i = 0; i < n; i++) begin
            i_host.rbyte(i == n - 1, b);
            val = {val[7:0], b};
        end
        i_host.stop();
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #500000;
        failures++;
        complete_run();
    end
    initial begin
        void'($urandom(30518));
        repeat (10) @(negedge sys_clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        for (int i = 0; i < 5; i++) begin
            rd(RD_OFS[i], (i > 2) ? 2 : 1, v);
            chk("reg_read", RD_EXP[i], v);
        end
        $display("test identity done");
        wr(8'h30, 1, 72'h0);
        rd(8'h30, 1, v);
        wr(8'h01, 1, 72'h07);
        @(negedge sys_clk_i);
        {max_resist_i, hotplate_current_fault_i, hotplate_voltage_fault_i} = 3'h7;
        repeat (2) @(negedge sys_clk_i);
        {max_resist_i, hotplate_current_fault_i, hotplate_voltage_fault_i} = 3'h0;
        exp_st |= 'h01;
        rd(8'hE0, 1, v);
        chk("fault_source", 16'h003F, v);
        $display("test faults done");
        wr(8'hFF, 4, 72'h11E5728B);
        wr(8'hF1, 3, 72'hE7A7E6);
        wr(8'hF1, 4, 72'hE7A7E609);
        rd(8'h00, 1, v);
        chk("status", 16'(exp_st), v);
        chk("wipe_starts", 16'h0001, 16'(wipes));
        chk("early_restarts", 16'h0000, 16'(restarts));
        @(negedge sys_clk_i);
        wipe_done_i = 1'b1;
        @(negedge sys_clk_i);
        wipe_done_i = 1'b0;
        exp_st |= 'h40;
        rd(8'h00, 1, v);
        chk("status", 16'(exp_st), v);
        for (int i = 0; i < 3; i++) begin
            wr(8'hF2, 9, 72'({$urandom, $urandom, $urandom}));
        end
        wr(8'hF3, 1, 72'h0);
        rd(8'h00, 1, v);
        chk("chunk_count", 16'h0003, 16'(chunk_count_o));
        chk("verify_starts", 16'h0001, 16'(verifies));
        @(negedge sys_clk_i);
        check_pass_i = 1'b1;
        check_done_i = 1'b1;
        @(negedge sys_clk_i);
        check_done_i = 1'b0;
        exp_st |= 'h30;
        rd(8'h00, 1, v);
        chk("status", 16'(exp_st), v);
        $display("test update done");
        wr(8'hF4, 0, 72'h0);
        i_host.start();
        i_host.stop();
        repeat (8) @(negedge sys_clk_i);
        chk("app_run", 16'h0001, 16'(app_run_o));
        addr_sel_i = 1'b1;
        i_host.start();
        i_host.wbyte({7'h5A, 1'b0}, ack);
        i_host.stop();
        chk("other_addr_ack", 16'h0000, 16'(ack));
        dev = 7'h5B;
        wr(8'hFF, 4, 72'h11E5728A);
        i_host.start();
        i_host.stop();
        repeat (8) @(negedge sys_clk_i);
        chk("restarts", 16'h0001, 16'(restarts));
        $display("test launch and restart done");
        complete_run();
    end
endmodule
